// >>> bench/host_link_interrupt_mask_tb_top.sv
// Self-checking bench for the host link interrupt enable mask.
// Assumes the design package is compiled first; bench drives all inputs.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module host_link_interrupt_mask_tb_top;
	import host_link_irq_pkg::*;

	typedef struct {
		logic [31:0] set;
		logic [31:0] clr;
		logic [31:0] ev;
		logic [31:0] mask;
		logic        irq;
	} row_type;

	logic              clk_sys;
	logic              rst;
	logic [31:0]       event_in;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [DATA_W-1:0] reg_rdata;
	logic              link_irq;
	logic              ctl_irq;
	int                err_total;
	int                n_tests;
	logic [31:0]       d;

	// Set, clear, event, expected mask, expected interrupt
	row_type rows [16] = '{
		'{32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'hEFFF_83FF, 1'b0},
		'{32'hFFFF_FFFF, 32'h8000_0000, 32'h7FFF_FFFF, 32'h6FFF_83FF, 1'b0},
		'{32'h8000_0020, 32'h0000_0000, 32'h0000_0020, 32'h8000_0020, 1'b1},
		'{32'h8000_0020, 32'h0000_0000, 32'h0000_0010, 32'h8000_0020, 1'b0},
		'{32'hC000_0000, 32'h0000_0000, 32'h4000_0000, 32'hC000_0000, 1'b1},
		'{32'hA000_0000, 32'h0000_0000, 32'h2000_0000, 32'hA000_0000, 1'b1},
		'{32'h8C00_0000, 32'h0400_0000, 32'h0400_0000, 32'h8800_0000, 1'b0},
		'{32'h8300_0000, 32'h0000_0000, 32'h0100_0000, 32'h8300_0000, 1'b1},
		'{32'h80F0_0000, 32'h0000_0000, 32'h0010_0000, 32'h80F0_0000, 1'b1},
		'{32'h800C_0000, 32'h0000_0000, 32'h0004_0000, 32'h800C_0000, 1'b1},
		'{32'h8003_8000, 32'h0000_0000, 32'h0000_8000, 32'h8003_8000, 1'b1},
		'{32'h8000_0300, 32'h0000_0000, 32'h0000_0200, 32'h8000_0300, 1'b1},
		'{32'h8000_00C0, 32'h0000_0000, 32'h0000_0040, 32'h8000_00C0, 1'b1},
		'{32'h8000_000F, 32'h0000_0000, 32'h0000_0001, 32'h8000_000F, 1'b1},
		'{32'h9000_7C00, 32'h0000_0000, 32'h1000_7C00, 32'h8000_0000, 1'b0},
		'{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h8000_0000, 32'h8000_0000, 1'b0}
	};

	host_link_interrupt_mask u_dut (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.event_in  (event_in),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.link_irq  (link_irq),
		.ctl_irq   (ctl_irq)
	);

	// 10 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// One-cycle write, then a quiet cycle so strobes never merge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	// One-cycle read; data sampled in the single cycle it stands
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
		@(posedge clk_sys);
	endtask

	// Look at settled outputs mid-cycle, then realign to the edge
	task automatic chk_out(input logic l, input logic c);
		@(negedge clk_sys);
		`CHK("link_irq", l, link_irq)
		`CHK("ctl_irq", c, ctl_irq)
		@(posedge clk_sys);
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		$display("ERROR watchdog expected finish seen hang");
		end_of_test();
	end

	// Main sequence
	initial begin
		err_total = 0;
		n_tests = 0;
		rst = 1'b1;
		event_in = '0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		// Reset values
		rd(OFS_MASK_SET, d);
		`CHK("mask reset", MASK_RESET, d)
		chk_out(1'b0, 1'b0);
		$display("test reset done");
		// Table of mask and gating cases
		foreach (rows[i]) begin
			wr(OFS_MASK_CLR, 32'hFFFF_FFFF);
			event_in <= rows[i].ev;
			wr(OFS_MASK_SET, rows[i].set);
			wr(OFS_MASK_CLR, rows[i].clr);
			rd(OFS_MASK_SET, d);
			`CHK("mask via set", rows[i].mask, d)
			rd(OFS_MASK_CLR, d);
			`CHK("mask via clear", rows[i].mask, d)
			@(negedge clk_sys);
			`CHK("link_irq row", rows[i].irq, link_irq)
			@(posedge clk_sys);
		end
		$display("test table done");
		// Set accumulates, zeros in clear change nothing
		event_in <= '0;
		wr(OFS_MASK_CLR, 32'hFFFF_FFFF);
		wr(OFS_MASK_SET, 32'h0000_0001);
		wr(OFS_MASK_SET, 32'h0000_0002);
		wr(OFS_MASK_CLR, 32'h0000_0000);
		rd(OFS_MASK_SET, d);
		`CHK("mask accumulate", 32'h0000_0003, d)
		@(negedge clk_sys);
		`CHK("rdata idle", ZERO_WORD, reg_rdata)
		@(posedge clk_sys);
		wr(OFS_MASK_CLR, 32'h0000_0001);
		rd(OFS_MASK_CLR, d);
		`CHK("mask partial clear", 32'h0000_0002, d)
		$display("test set clear done");
		// Status: unmapped access, masked, unmasked, cleared
		wr(OFS_STAT, 32'h0000_0003);
		wr(OFS_STAT_MASK, 32'h0000_0000);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, d);
		`CHK("unmapped read", ZERO_WORD, d)
		rd(OFS_MASK_SET, d);
		`CHK("mask after bad write", 32'h0000_0002, d)
		rd(OFS_STAT, d);
		`CHK("status bad access", 32'h0000_0002, d)
		chk_out(1'b0, 1'b0);
		wr(OFS_STAT_MASK, 32'h0000_0002);
		chk_out(1'b0, 1'b1);
		wr(OFS_STAT, 32'h0000_0002);
		chk_out(1'b0, 1'b0);
		// Link interrupt rise sets status bit 0
		wr(OFS_MASK_SET, 32'h8000_0001);
		event_in <= 32'h0000_0001;
		@(posedge clk_sys);
		chk_out(1'b1, 1'b0);
		rd(OFS_STAT, d);
		`CHK("status irq rise", 32'h0000_0001, d)
		wr(OFS_STAT_MASK, 32'h0000_0001);
		chk_out(1'b1, 1'b1);
		wr(OFS_MASK_CLR, 32'h8000_0000);
		wr(OFS_STAT, 32'h0000_0001);
		chk_out(1'b0, 1'b0);
		$display("test status done");
		// Reset in mid-run returns the mask to zero
		wr(OFS_MASK_SET, 32'hFFFF_FFFF);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		rd(OFS_MASK_CLR, d);
		`CHK("mask after reset", MASK_RESET, d)
		chk_out(1'b0, 1'b0);
		$display("test second reset done");
		end_of_test();
	end
endmodule

// >>> design/host_link_interrupt_mask.sv
// Interrupt enable mask with set/clear ports and the link interrupt output.
// Assumes event_in comes from the event register logic on clk_sys.
`timescale 1ns/1ps

module host_link_interrupt_mask
	import host_link_irq_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [31:0]       event_in,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	output logic                   link_irq,
	output logic                   ctl_irq
);

	// Offset decoder shared by read and write paths
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		is_mapped = (a == OFS_MASK_SET) || (a == OFS_MASK_CLR) ||
			(a == OFS_STAT) || (a == OFS_STAT_MASK);
	endfunction

	// Group hit: any event bit of the group meets its enable
	function automatic logic grp_hit(
		input logic [31:0] ev,
		input logic [31:0] en,
		input logic [31:0] grp
	);
		grp_hit = |(ev & en & grp);
	endfunction

	// State
	logic [31:0]       mask;
	logic [STAT_W-1:0] status;
	logic [STAT_W-1:0] stat_mask;

	// Next values
	logic [31:0]       next_mask;
	logic [STAT_W-1:0] next_status;
	logic [STAT_W-1:0] next_stat_mask;
	logic [DATA_W-1:0] next_rdata;
	logic              next_link_irq;
	logic              next_ctl_irq;

	// Decode
	logic              hit_set;
	logic              hit_clr;
	logic              hit_stat;
	logic              hit_stat_mask;
	logic              rd_mask;
	logic [31:0]       set_bits;
	logic [31:0]       clr_bits;
	logic [STAT_W-1:0] stat_clr_bits;
	logic [STAT_W-1:0] stat_events;
	logic [DATA_W-1:0] rd_value;

	// Named enables
	logic global_irq_gate;
	logic maker_defined_source_en;
	logic software_raised_source_en;
	logic late_ack_en;
	logic phy_register_arrived_en;
	logic cycle_overrun_en;
	logic fatal_fault_en;
	logic cycle_mismatch_en;
	logic missed_cycle_en;
	logic sixty_four_second_rollover_en;
	logic cycle_start_en;
	logic phy_status_en;
	logic register_access_fault_en;
	logic link_reinit_en;
	logic node_identify_done_en;
	logic node_identify_done_sticky_en;
	logic atomic_reply_fault_en;
	logic buffered_write_fault_en;
	logic timed_receive_dma_en;
	logic timed_transmit_dma_en;
	logic reply_packet_arrived_en;
	logic request_packet_arrived_en;
	logic async_reply_receive_dma_en;
	logic async_request_receive_dma_en;
	logic reply_send_done_en;
	logic request_send_done_en;

	// Group hits
	logic hit_maker;
	logic hit_soft;
	logic hit_ack_phy;
	logic hit_ovr_ftl;
	logic hit_cycle;
	logic hit_phy_reg;
	logic hit_node;
	logic hit_wr_flt;
	logic hit_timed;
	logic hit_packet;
	logic hit_async;
	logic any_hit;

	// Register port decode
	assign hit_set       = reg_wr && (reg_addr == OFS_MASK_SET);
	assign hit_clr       = reg_wr && (reg_addr == OFS_MASK_CLR);
	assign hit_stat      = reg_wr && (reg_addr == OFS_STAT);
	assign hit_stat_mask = reg_wr && (reg_addr == OFS_STAT_MASK);
	assign rd_mask       = (reg_addr == OFS_MASK_SET) ||
		(reg_addr == OFS_MASK_CLR);

	// Mask update: ones set or clear, reserved bits stay zero
	assign set_bits  = reg_wdata & {32{hit_set}};
	assign clr_bits  = reg_wdata & {32{hit_clr}};
	assign next_mask = ((mask | set_bits) & ~clr_bits) &
		MASK_WRITABLE;

	// Named views of the mask
	assign global_irq_gate               = mask[BIT_GLOBAL_GATE];
	assign maker_defined_source_en       = mask[BIT_MAKER];
	assign software_raised_source_en     = mask[BIT_SOFT];
	assign late_ack_en                   = mask[BIT_LATE_ACK];
	assign phy_register_arrived_en       = mask[BIT_PHY_REG];
	assign cycle_overrun_en              = mask[BIT_CYC_OVERRUN];
	assign fatal_fault_en                = mask[BIT_FATAL];
	assign cycle_mismatch_en             = mask[BIT_CYC_MISMATCH];
	assign missed_cycle_en               = mask[BIT_CYC_MISSED];
	assign sixty_four_second_rollover_en = mask[BIT_ROLLOVER];
	assign cycle_start_en                = mask[BIT_CYC_START];
	assign phy_status_en                 = mask[BIT_PHY_STATUS];
	assign register_access_fault_en      = mask[BIT_REG_FAULT];
	assign link_reinit_en                = mask[BIT_LINK_REINIT];
	assign node_identify_done_en         = mask[BIT_NODE_DONE];
	assign node_identify_done_sticky_en  = mask[BIT_NODE_STICKY];
	assign atomic_reply_fault_en         = mask[BIT_ATOMIC_FAULT];
	assign buffered_write_fault_en       = mask[BIT_BUF_WR_FAULT];
	assign timed_receive_dma_en          = mask[BIT_TIMED_RX];
	assign timed_transmit_dma_en         = mask[BIT_TIMED_TX];
	assign reply_packet_arrived_en       = mask[BIT_REPLY_PKT];
	assign request_packet_arrived_en     = mask[BIT_REQUEST_PKT];
	assign async_reply_receive_dma_en    = mask[BIT_ASYNC_REPLY];
	assign async_request_receive_dma_en  = mask[BIT_ASYNC_REQUEST];
	assign reply_send_done_en            = mask[BIT_REPLY_DONE];
	assign request_send_done_en          = mask[BIT_REQUEST_DONE];

	// Per-group gating, each enable on its own event position
	assign hit_maker   = maker_defined_source_en &&
		event_in[BIT_MAKER];
	assign hit_soft    = software_raised_source_en &&
		event_in[BIT_SOFT];
	assign hit_ack_phy = grp_hit(event_in, mask, GRP_ACK_PHY);
	assign hit_ovr_ftl = grp_hit(event_in, mask, GRP_OVR_FTL);
	assign hit_cycle   = grp_hit(event_in, mask, GRP_CYCLE);
	assign hit_phy_reg = grp_hit(event_in, mask, GRP_PHY_REG);
	assign hit_node    = grp_hit(event_in, mask, GRP_NODE);
	assign hit_wr_flt  = grp_hit(event_in, mask, GRP_WR_FLT);
	assign hit_timed   = grp_hit(event_in, mask, GRP_TIMED);
	assign hit_packet  = grp_hit(event_in, mask, GRP_PACKET);
	assign hit_async   = grp_hit(event_in, mask, GRP_ASYNC);

	// Any source, then the global gate
	assign any_hit = hit_maker || hit_soft || hit_ack_phy ||
		hit_ovr_ftl || hit_cycle || hit_phy_reg || hit_node ||
		hit_wr_flt || hit_timed || hit_packet || hit_async;
	assign next_link_irq = global_irq_gate && any_hit;

	// Block status: rising link interrupt and unmapped access
	assign stat_events[STAT_IRQ_RISE]   = next_link_irq && !link_irq;
	assign stat_events[STAT_BAD_ACCESS] = (reg_wr || reg_rd) &&
		!is_mapped(reg_addr);
	assign stat_clr_bits  = reg_wdata[STAT_W-1:0] & {STAT_W{hit_stat}};
	assign next_status    = (status & ~stat_clr_bits) | stat_events;
	assign next_stat_mask = hit_stat_mask ? reg_wdata[STAT_W-1:0] :
		stat_mask;
	assign next_ctl_irq   = |(next_status & next_stat_mask);

	// Read selection, unmapped reads give zero
	assign rd_value =
		rd_mask ? mask :
		(reg_addr == OFS_STAT) ?
			{{(DATA_W-STAT_W){1'b0}}, status} :
		(reg_addr == OFS_STAT_MASK) ?
			{{(DATA_W-STAT_W){1'b0}}, stat_mask} :
		ZERO_WORD;
	assign next_rdata = reg_rd ? rd_value : ZERO_WORD;

	// Mask register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mask <= MASK_RESET;
		end else begin
			mask <= next_mask;
		end
	end

	// Status and status mask
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			status    <= STAT_RESET;
			stat_mask <= STAT_RESET;
		end else begin
			status    <= next_status;
			stat_mask <= next_stat_mask;
		end
	end

	// Outputs from flip-flops
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= ZERO_WORD;
			link_irq  <= 1'b0;
			ctl_irq   <= 1'b0;
		end else begin
			reg_rdata <= next_rdata;
			link_irq  <= next_link_irq;
			ctl_irq   <= next_ctl_irq;
		end
	end

	// Checks
	default clocking chk_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Both offsets read back the mask
	a_read_both_ports: assert property (
		reg_rd && rd_mask |=> reg_rdata == $past(mask)
	) else $error("mask readback differs from mask");

	// Set write raises written ones
	a_set_raises_ones: assert property (
		hit_set |=>
			((mask & $past(reg_wdata) & MASK_WRITABLE) ==
			($past(reg_wdata) & MASK_WRITABLE))
	) else $error("set write did not set bits");

	// Set write leaves zero positions alone
	a_set_keeps_zeros: assert property (
		hit_set |=> (((mask ^ $past(mask)) & ~$past(reg_wdata)) == 0)
	) else $error("set write changed unwritten bits");

	// Clear write lowers written ones
	a_clear_lowers_ones: assert property (
		hit_clr |=> ((mask & $past(reg_wdata)) == 0)
	) else $error("clear write left bits set");

	// Bits fall only by a clear write
	a_clear_only_path: assert property (
		!hit_clr |=> (($past(mask) & ~mask) == 0)
	) else $error("mask bit fell without clear write");

	// Bit 28 stays zero in state and readback
	a_rsvd_hi_zero: assert property (
		reg_rd |=> !reg_rdata[BIT_RSVD_HI] && !mask[BIT_RSVD_HI]
	) else $error("reserved bit 28 not zero");

	// Bits 14 to 10 stay zero in state and readback
	a_rsvd_lo_zero: assert property (
		reg_rd |=> reg_rdata[BIT_RSVD_LO_TOP:BIT_RSVD_LO_BOT] == 0 &&
			mask[BIT_RSVD_LO_TOP:BIT_RSVD_LO_BOT] == 0
	) else $error("reserved bits 14 to 10 not zero");

	// Closed gate keeps the output low
	a_gate_blocks_irq: assert property (
		!global_irq_gate |=> !link_irq
	) else $error("interrupt while gate closed");

	// Output tracks gated sources one cycle on
	a_irq_tracks_hits: assert property (
		##1 link_irq == ($past(global_irq_gate) && $past(any_hit))
	) else $error("interrupt does not match sources");

	// Maker source fires with both bits set
	a_maker_needs_both: assert property (
		global_irq_gate && mask[BIT_MAKER] && event_in[BIT_MAKER]
		|=> link_irq
	) else $error("maker-defined source did not interrupt");

	// Software source alone needs its event bit
	a_soft_needs_event: assert property (
		global_irq_gate && mask[BIT_SOFT] && !event_in[BIT_SOFT] &&
		((event_in[30:0] & mask[30:0] & ~GRP_SOFT[30:0]) == 0)
		|=> !link_irq
	) else $error("software source fired without event");

	// Single aligned hit is enough
	a_aligned_single: assert property (
		global_irq_gate && $onehot(event_in[30:0] & mask[30:0])
		|=> link_irq
	) else $error("aligned enable did not interrupt");

	// Late acknowledge and PHY register sources reach the output
	a_ack_phy_gated: assert property (
		global_irq_gate &&
		((late_ack_en && event_in[BIT_LATE_ACK]) ||
		(phy_register_arrived_en && event_in[BIT_PHY_REG]))
		|=> link_irq
	) else $error("late ack or PHY register source did not interrupt");

	// Overrun and fatal fault sources reach the output
	a_ovr_ftl_gated: assert property (
		global_irq_gate &&
		((cycle_overrun_en && event_in[BIT_CYC_OVERRUN]) ||
		(fatal_fault_en && event_in[BIT_FATAL]))
		|=> link_irq
	) else $error("overrun or fatal fault source did not interrupt");

	// Cycle timing sources reach the output
	a_cycle_gated: assert property (
		global_irq_gate &&
		((cycle_mismatch_en && event_in[BIT_CYC_MISMATCH]) ||
		(missed_cycle_en && event_in[BIT_CYC_MISSED]) ||
		(sixty_four_second_rollover_en && event_in[BIT_ROLLOVER]) ||
		(cycle_start_en && event_in[BIT_CYC_START]))
		|=> link_irq
	) else $error("cycle timing source did not interrupt");

	// PHY status and register fault sources reach the output
	a_phy_reg_gated: assert property (
		global_irq_gate &&
		((phy_status_en && event_in[BIT_PHY_STATUS]) ||
		(register_access_fault_en && event_in[BIT_REG_FAULT]))
		|=> link_irq
	) else $error("PHY status or register fault source did not interrupt");

	// Link reinit and node identify sources reach the output
	a_node_gated: assert property (
		global_irq_gate &&
		((link_reinit_en && event_in[BIT_LINK_REINIT]) ||
		(node_identify_done_en && event_in[BIT_NODE_DONE]) ||
		(node_identify_done_sticky_en && event_in[BIT_NODE_STICKY]))
		|=> link_irq
	) else $error("link reinit or node identify source did not interrupt");

	// Atomic reply and buffered write faults reach the output
	a_wr_flt_gated: assert property (
		global_irq_gate &&
		((atomic_reply_fault_en && event_in[BIT_ATOMIC_FAULT]) ||
		(buffered_write_fault_en && event_in[BIT_BUF_WR_FAULT]))
		|=> link_irq
	) else $error("atomic or buffered write fault did not interrupt");

	// Timed receive and transmit DMA sources reach the output
	a_timed_gated: assert property (
		global_irq_gate &&
		((timed_receive_dma_en && event_in[BIT_TIMED_RX]) ||
		(timed_transmit_dma_en && event_in[BIT_TIMED_TX]))
		|=> link_irq
	) else $error("timed DMA source did not interrupt");

	// Packet arrival sources reach the output
	a_packet_gated: assert property (
		global_irq_gate &&
		((reply_packet_arrived_en && event_in[BIT_REPLY_PKT]) ||
		(request_packet_arrived_en && event_in[BIT_REQUEST_PKT]))
		|=> link_irq
	) else $error("packet arrival source did not interrupt");

	// Async receive DMA and send done sources reach the output
	a_async_gated: assert property (
		global_irq_gate &&
		((async_reply_receive_dma_en && event_in[BIT_ASYNC_REPLY]) ||
		(async_request_receive_dma_en && event_in[BIT_ASYNC_REQUEST]) ||
		(reply_send_done_en && event_in[BIT_REPLY_DONE]) ||
		(request_send_done_en && event_in[BIT_REQUEST_DONE]))
		|=> link_irq
	) else $error("async DMA or send done source did not interrupt");

	// Status event wins over a same-cycle clear
	a_status_set_wins: assert property (
		stat_events[STAT_BAD_ACCESS] |=> status[STAT_BAD_ACCESS]
	) else $error("status event lost");

endmodule

// >>> design/host_link_irq_pkg.sv
// Constants for the host link interrupt enable block.
// Assumes a byte-addressed register port with 8 address bits.
package host_link_irq_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STAT_W = 2;

	// Register byte offsets
	localparam logic [7:0] OFS_MASK_SET  = 8'h88;
	localparam logic [7:0] OFS_MASK_CLR  = 8'h8C;
	localparam logic [7:0] OFS_STAT      = 8'hF0;
	localparam logic [7:0] OFS_STAT_MASK = 8'hF4;

	// Mask register reset and implemented bits
	localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
	localparam logic [31:0] MASK_WRITABLE = 32'hEFFF_83FF;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

	// Special bit positions
	localparam int BIT_GLOBAL_GATE = 31;
	localparam int BIT_MAKER       = 30;
	localparam int BIT_SOFT        = 29;
	localparam int BIT_RSVD_HI     = 28;
	localparam int BIT_RSVD_LO_TOP = 14;
	localparam int BIT_RSVD_LO_BOT = 10;

	// Per-source enable positions
	localparam int BIT_LATE_ACK      = 27;
	localparam int BIT_PHY_REG       = 26;
	localparam int BIT_CYC_OVERRUN   = 25;
	localparam int BIT_FATAL         = 24;
	localparam int BIT_CYC_MISMATCH  = 23;
	localparam int BIT_CYC_MISSED    = 22;
	localparam int BIT_ROLLOVER      = 21;
	localparam int BIT_CYC_START     = 20;
	localparam int BIT_PHY_STATUS    = 19;
	localparam int BIT_REG_FAULT     = 18;
	localparam int BIT_LINK_REINIT   = 17;
	localparam int BIT_NODE_DONE     = 16;
	localparam int BIT_NODE_STICKY   = 15;
	localparam int BIT_ATOMIC_FAULT  = 9;
	localparam int BIT_BUF_WR_FAULT  = 8;
	localparam int BIT_TIMED_RX      = 7;
	localparam int BIT_TIMED_TX      = 6;
	localparam int BIT_REPLY_PKT     = 5;
	localparam int BIT_REQUEST_PKT   = 4;
	localparam int BIT_ASYNC_REPLY   = 3;
	localparam int BIT_ASYNC_REQUEST = 2;
	localparam int BIT_REPLY_DONE    = 1;
	localparam int BIT_REQUEST_DONE  = 0;

	// Source groups, together covering every enable below the gate
	localparam logic [31:0] GRP_MAKER   = 32'h4000_0000;
	localparam logic [31:0] GRP_SOFT    = 32'h2000_0000;
	localparam logic [31:0] GRP_ACK_PHY = 32'h0C00_0000;
	localparam logic [31:0] GRP_OVR_FTL = 32'h0300_0000;
	localparam logic [31:0] GRP_CYCLE   = 32'h00F0_0000;
	localparam logic [31:0] GRP_PHY_REG = 32'h000C_0000;
	localparam logic [31:0] GRP_NODE    = 32'h0003_8000;
	localparam logic [31:0] GRP_WR_FLT  = 32'h0000_0300;
	localparam logic [31:0] GRP_TIMED   = 32'h0000_00C0;
	localparam logic [31:0] GRP_PACKET  = 32'h0000_0030;
	localparam logic [31:0] GRP_ASYNC   = 32'h0000_000F;

	// Block status bits
	localparam int STAT_IRQ_RISE   = 0;
	localparam int STAT_BAD_ACCESS = 1;
	localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

endpackage
